// ===== hw/flash_section_guard.sv
`include "fsg_regs.svh"
module flash_section_guard
	import fsg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`FSG_AW-1:0] boot_start,
	input wire logic [`FSG_AW-1:0] region_limit,
	input wire logic vectors_in_boot,
	input wire logic [`FSG_AW-1:0] exec_addr,
	input wire logic store_valid,
	input wire logic [1:0] store_kind,
	input wire logic [`FSG_AW-1:0] store_addr,
	input wire logic flash_done,
	input wire logic load_valid,
	input wire logic [`FSG_AW-1:0] load_addr,
	input wire logic fetch_valid,
	input wire logic [`FSG_AW-1:0] fetch_addr,
	input wire logic ext_lock_wr,
	input wire logic [`FSG_LOCK_W-1:0] ext_lock_data,
	input wire logic chip_erase,
	output logic store_accept,
	output logic store_reject,
	output logic cpu_halt,
	output logic load_allow,
	output logic fetch_allow,
	output logic irq_disable,
	output logic upper_region_busy
);

	prog_state_t state;
	prog_state_t next_state;
	logic [`FSG_LOCK_W-1:0] lock;
	logic reject_seen;
	logic [`FSG_AW-1:0] boot_eff;
	logic exec_boot;
	logic st_boot;
	logic st_upper;
	logic ld_boot;
	logic ld_upper;
	logic fetch_upper;
	logic prog_kind;
	logic kind_ok;
	logic lock_ok;
	logic store_ok;
	logic busy_set;
	logic busy_clr;
	logic setup_rd;
	logic apb_wr;
	logic reen_wr;
	logic lock_wr;
	logic rej_clr;
	logic mapped;
	logic [31:0] next_prdata;

	lock_if app_if();
	lock_if boot_if();

	lock_decode u_app_lock (
		.field(lock[`FSG_LOCK_APP_LSB +: 2]),
		.perm(app_if)
	);

	lock_decode u_boot_lock (
		.field(lock[`FSG_LOCK_BOOT_LSB +: 2]),
		.perm(boot_if)
	);

	// Section decode.
	// boot clamped high
	// A misconfigured boot start below the boundary is pulled up to it, so
	// the boot loader can never be caught in a busy-tolerant page.
	assign boot_eff = (boot_start < region_limit) ? region_limit : boot_start;

	assign exec_boot = exec_addr >= boot_eff;
	assign st_boot = store_addr >= boot_eff;
	assign st_upper = store_addr < region_limit;
	assign ld_boot = load_addr >= boot_eff;
	assign ld_upper = load_addr < region_limit;
	assign fetch_upper = fetch_addr < region_limit;

	assign prog_kind = (store_kind == OP_ERASE) || (store_kind == OP_WRITE);
	assign kind_ok = prog_kind || (store_kind == OP_BUF_LOAD);

	// The general lock bits are held but never consulted here on purpose.
	// general lock ignored
	always_comb begin
		lock_ok = 1'b1;
		if (prog_kind) begin
			if (st_boot)
				lock_ok = !boot_if.store_block;
			else
				lock_ok = !app_if.store_block;
		end
	end

	// Stores only run from boot code and only when the flash is idle.
	assign store_ok = store_valid && (state == ST_IDLE) && exec_boot &&
		kind_ok && lock_ok;

	// APB decode.
	assign setup_rd = psel && !penable;
	assign apb_wr = psel && penable && pready && pwrite;
	assign mapped = (paddr == `FSG_OFS_CTRL) || (paddr == `FSG_OFS_LOCK) ||
		(paddr == `FSG_OFS_STATUS);
	assign reen_wr = apb_wr && (paddr == `FSG_OFS_CTRL) &&
		pwdata[`FSG_CTRL_REEN_BIT];
	assign lock_wr = apb_wr && (paddr == `FSG_OFS_LOCK);
	assign rej_clr = apb_wr && (paddr == `FSG_OFS_STATUS) &&
		pwdata[`FSG_STAT_REJ_BIT];

	// Busy flag terms.
	// set on start
	assign busy_set = store_ok && prog_kind && st_upper;
	assign busy_clr = (reen_wr && (state == ST_IDLE)) ||
		(store_ok && (store_kind == OP_BUF_LOAD));

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (store_ok && prog_kind) begin
					if (st_upper)
						next_state = ST_PROG_UPPER;
					else
						next_state = ST_PROG_HALT;
				end
			end
			ST_PROG_UPPER: begin
				if (flash_done)
					next_state = ST_IDLE;
			end
			ST_PROG_HALT: begin
				if (flash_done)
					next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cpu_halt <= 1'b0;
		else
			cpu_halt <= (next_state == ST_PROG_HALT);
	end

	// Set wins over clear so a start in the clearing cycle is not lost.
	// set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			upper_region_busy <= 1'b0;
		else if (busy_set)
			upper_region_busy <= 1'b1;
		else if (busy_clr)
			upper_region_busy <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_accept <= 1'b0;
			store_reject <= 1'b0;
		end else begin
			store_accept <= store_ok;
			store_reject <= store_valid && !store_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			reject_seen <= 1'b0;
		else if (store_valid && !store_ok)
			reject_seen <= 1'b1;
		else if (rej_clr)
			reject_seen <= 1'b0;
	end

	// Lock bits can only go from one to zero; only chip erase restores
	// them. A reset also restores them since no non-volatile cell is
	// modelled here.
	// program only erase clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lock <= `FSG_LOCK_RESET;
		else if (chip_erase)
			lock <= `FSG_LOCK_RESET;
		else if (lock_wr && ext_lock_wr)
			lock <= lock & pwdata[`FSG_LOCK_W-1:0] & ext_lock_data;
		else if (lock_wr)
			lock <= lock & pwdata[`FSG_LOCK_W-1:0];
		else if (ext_lock_wr)
			lock <= lock & ext_lock_data;
	end

	// Loads are granted a cycle after the request.
	// busy region unreadable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			load_allow <= 1'b0;
		else
			load_allow <= load_valid && (state != ST_PROG_HALT) &&
				!(ld_upper && upper_region_busy) &&
				!(exec_boot && !ld_boot && app_if.load_block) &&
				!(!exec_boot && ld_boot && boot_if.load_block);
	end

	// Fetches from busy-tolerant code are refused until software clears
	// the flag, which covers stray interrupts the software failed to mask.
	// fetch blocked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fetch_allow <= 1'b0;
		else
			fetch_allow <= fetch_valid && (state != ST_PROG_HALT) &&
				!(fetch_upper && upper_region_busy);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_disable <= 1'b0;
		else
			irq_disable <= (!exec_boot && app_if.irq_block &&
				vectors_in_boot) || (exec_boot && boot_if.irq_block &&
				!vectors_in_boot);
	end

	// Read data is captured in the setup cycle so it is stable in access.
	// busy flag readable
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`FSG_OFS_CTRL: begin
				next_prdata[`FSG_CTRL_BUSY_BIT] = upper_region_busy;
			end
			`FSG_OFS_LOCK: begin
				next_prdata[`FSG_LOCK_W-1:0] = lock;
			end
			`FSG_OFS_STATUS: begin
				next_prdata[`FSG_STAT_UPPER_BIT] = state == ST_PROG_UPPER;
				next_prdata[`FSG_STAT_HALT_BIT] = state == ST_PROG_HALT;
				next_prdata[`FSG_STAT_REJ_BIT] = reject_seen;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_rd;
			pslverr <= setup_rd && !mapped;
			if (setup_rd)
				prdata <= next_prdata;
		end
	end

	property p_halt_start;
		@(posedge pclk) disable iff (!presetn)
		(store_ok && prog_kind && !st_upper) |=> cpu_halt;
	endproperty
	a_halt_start: assert property (p_halt_start)
		else $error("halting store did not halt the cpu");

	property p_halt_hold;
		@(posedge pclk) disable iff (!presetn)
		(cpu_halt && !flash_done) |=> cpu_halt && !fetch_allow;
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("cpu released before flash done");

	property p_upper_runs;
		@(posedge pclk) disable iff (!presetn)
		(store_ok && prog_kind && st_upper) |=> !cpu_halt [*2];
	endproperty
	a_upper_runs: assert property (p_upper_runs)
		else $error("cpu halted for busy-tolerant programming");

	property p_busy_set;
		@(posedge pclk) disable iff (!presetn)
		busy_set |=> upper_region_busy;
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy flag not set at program start");

	property p_busy_fetch;
		@(posedge pclk) disable iff (!presetn)
		(upper_region_busy && fetch_valid && fetch_upper) |=> !fetch_allow;
	endproperty
	a_busy_fetch: assert property (p_busy_fetch)
		else $error("busy-tolerant fetch granted while busy");

	property p_busy_read;
		@(posedge pclk) disable iff (!presetn)
		(setup_rd && !pwrite && paddr == `FSG_OFS_CTRL && upper_region_busy)
		##1 pready |-> prdata[`FSG_CTRL_BUSY_BIT];
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy flag read as zero while busy");

	property p_reen_early;
		@(posedge pclk) disable iff (!presetn)
		(reen_wr && state != ST_IDLE && upper_region_busy) |=>
			upper_region_busy;
	endproperty
	a_reen_early: assert property (p_reen_early)
		else $error("busy cleared before programming done");

	property p_bufload_clr;
		@(posedge pclk) disable iff (!presetn)
		(store_ok && store_kind == OP_BUF_LOAD) |=> !upper_region_busy;
	endproperty
	a_bufload_clr: assert property (p_bufload_clr)
		else $error("buffer load left busy flag set");

	property p_app_store;
		@(posedge pclk) disable iff (!presetn)
		(store_valid && prog_kind && !st_boot && !lock[0]) |=>
			store_reject && !store_accept;
	endproperty
	a_app_store: assert property (p_app_store)
		else $error("store into locked application section accepted");

	property p_boot_store;
		@(posedge pclk) disable iff (!presetn)
		(store_valid && prog_kind && st_boot && !lock[2]) |=>
			store_reject && !store_accept;
	endproperty
	a_boot_store: assert property (p_boot_store)
		else $error("store into locked boot section accepted");

	property p_lock_sticky;
		@(posedge pclk) disable iff (!presetn)
		!chip_erase |=> (lock & ~$past(lock)) == 6'h00;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock bit cleared without chip erase");

	property p_app_irq;
		@(posedge pclk) disable iff (!presetn)
		(!exec_boot && !lock[1] && vectors_in_boot) |=> irq_disable;
	endproperty
	a_app_irq: assert property (p_app_irq)
		else $error("interrupts not masked in application code");

endmodule // flash_section_guard

// ===== hw/fsg_pkg.sv
package fsg_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PROG_UPPER = 3'h2,
		ST_PROG_HALT = 3'h4
	} prog_state_t;

	typedef enum logic [1:0] {
		OP_BUF_LOAD = 2'h0,
		OP_ERASE = 2'h1,
		OP_WRITE = 2'h2,
		OP_NONE = 2'h3
	} store_kind_t;

endpackage

// ===== hw/fsg_regs.svh
`ifndef FSG_REGS_SVH
`define FSG_REGS_SVH

// Word address width of the program flash.
`define FSG_AW 15

// Register byte offsets on the APB slave.
`define FSG_OFS_CTRL 8'h00
`define FSG_OFS_LOCK 8'h04
`define FSG_OFS_STATUS 8'h08

// Control and status register fields.
`define FSG_CTRL_BUSY_BIT 6
`define FSG_CTRL_REEN_BIT 4

// Lock register fields.
`define FSG_LOCK_APP_LSB 0
`define FSG_LOCK_BOOT_LSB 2
`define FSG_LOCK_GEN_LSB 4
`define FSG_LOCK_W 6
`define FSG_LOCK_RESET 6'h3F

// Status register fields.
`define FSG_STAT_UPPER_BIT 0
`define FSG_STAT_HALT_BIT 1
`define FSG_STAT_REJ_BIT 2

`endif

// ===== hw/lock_decode.sv
module lock_decode (
	input wire logic [1:0] field,
	lock_if.decoder perm
);
	// Bit 0 programmed (0) forbids erase and write stores; bit 1 programmed forbids loads
	// from the other section and masks interrupts in its own while the vectors sit in the other.
	// none when 11
	assign perm.store_block = ~field[0];
	assign perm.load_block = ~field[1];
	assign perm.irq_block = ~field[1];
endmodule // lock_decode

// ===== hw/lock_if.sv
interface lock_if;
	logic store_block;
	logic load_block;
	logic irq_block;

	modport decoder (
		output store_block,
		output load_block,
		output irq_block
	);

	modport user (
		input store_block,
		input load_block,
		input irq_block
	);
endinterface

// ===== verification/cpu_model.sv
`include "fsg_regs.svh"
// Core that issues program store, program load and fetch requests.
module cpu_model (
	input wire logic pclk,
	output logic [`FSG_AW-1:0] exec_addr,
	output logic store_valid,
	output logic [1:0] store_kind,
	output logic [`FSG_AW-1:0] store_addr,
	output logic load_valid,
	output logic [`FSG_AW-1:0] load_addr,
	output logic fetch_valid,
	output logic [`FSG_AW-1:0] fetch_addr
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		exec_addr = 15'h7100;
		store_valid = 1'b0;
		store_kind = 2'h3;
		store_addr = 15'h0000;
		load_valid = 1'b0;
		load_addr = 15'h0000;
		fetch_valid = 1'b0;
		fetch_addr = 15'h0000;
	end

	task automatic run_at(input logic [`FSG_AW-1:0] a);
		@(posedge pclk);
		exec_addr <= a;
	endtask

	// Released fields show the inverse so nothing stale looks valid.
	task automatic store(input logic [1:0] k, input logic [`FSG_AW-1:0] a);
		@(posedge pclk);
		store_valid <= 1'b1;
		store_kind <= k;
		store_addr <= a;
		@(posedge pclk);
		store_valid <= 1'b0;
		store_kind <= ~k;
		store_addr <= ~a;
		#1;
	endtask

	task automatic read(input logic fetch, input logic [`FSG_AW-1:0] a);
		@(posedge pclk);
		fetch_valid <= fetch;
		load_valid <= ~fetch;
		fetch_addr <= a;
		load_addr <= a;
		@(posedge pclk);
		fetch_valid <= 1'b0;
		load_valid <= 1'b0;
		fetch_addr <= ~a;
		load_addr <= ~a;
		#1;
	endtask
endmodule // cpu_model

// ===== verification/tb.sv
`include "fsg_regs.svh"
`define CHK(g, w) begin \
	tests_run++; \
	if ((g) !== (w)) begin \
		bad_count++; \
		$display("FAIL t=%0t got %h want %h", $time, g, w); \
	end \
end

module tb import fsg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [14:0] BT = 15'h0100;
	localparam logic [14:0] HALT = 15'h6400;
	localparam logic [14:0] BOOT = 15'h7200;
	localparam logic [14:0] BEXEC = 15'h7100;
	localparam logic [14:0] AEXEC = 15'h0200;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e;
	logic vectors_in_boot = 1'b1;
	logic flash_done = 1'b0;
	logic ext_lock_wr = 1'b0;
	logic chip_erase = 1'b0;
	logic [5:0] ext_lock_data = 6'h3F;
	logic store_accept, store_reject, cpu_halt, load_allow, fetch_allow;
	logic irq_disable, upper_region_busy, store_valid, load_valid, fetch_valid;
	logic [1:0] store_kind;
	logic [14:0] exec_addr, store_addr, load_addr, fetch_addr;
	int bad_count = 0;
	int tests_run = 0;

	always #10 pclk = ~pclk;

	flash_section_guard dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.boot_start(15'h7000), .region_limit(15'h6000), .vectors_in_boot,
		.exec_addr, .store_valid, .store_kind, .store_addr, .flash_done,
		.load_valid, .load_addr, .fetch_valid, .fetch_addr, .ext_lock_wr,
		.ext_lock_data, .chip_erase, .store_accept, .store_reject, .cpu_halt,
		.load_allow, .fetch_allow, .irq_disable, .upper_region_busy);

	cpu_model cpu_u (.pclk, .exec_addr, .store_valid, .store_kind,
		.store_addr, .load_valid, .load_addr, .fetch_valid, .fetch_addr);

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			finish_test();
		end
		// Let the register updates of the access edge settle before checks.
		#1;
	endtask

	task automatic done_pulse;
		@(posedge pclk);
		flash_done <= 1'b1;
		@(posedge pclk);
		flash_done <= 1'b0;
		#1;
	endtask

	task automatic lock_pulse(input logic wr, input logic [5:0] d);
		@(posedge pclk);
		ext_lock_wr <= wr;
		chip_erase <= ~wr;
		ext_lock_data <= d;
		@(posedge pclk);
		ext_lock_wr <= 1'b0;
		chip_erase <= 1'b0;
	endtask

	task automatic irq_at(input logic [14:0] x, input logic v);
		cpu_u.run_at(x);
		vectors_in_boot <= v;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `FSG_OFS_LOCK, 32'h0);
		`CHK(r, 32'h3F)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK({e, r}, 33'h100000000)
		end_test("reset");
		cpu_u.store(OP_ERASE, BT);
		`CHK({store_accept, upper_region_busy, cpu_halt}, 3'h6)
		cpu_u.read(1'b1, HALT);
		`CHK(fetch_allow, 1'b1)
		cpu_u.read(1'b1, BT);
		`CHK(fetch_allow, 1'b0)
		cpu_u.read(1'b0, BT);
		`CHK(load_allow, 1'b0)
		apb(1'b0, `FSG_OFS_CTRL, 32'h0);
		`CHK(r[`FSG_CTRL_BUSY_BIT], 1'b1)
		apb(1'b1, `FSG_OFS_CTRL, 32'h10);
		`CHK(upper_region_busy, 1'b1)
		done_pulse();
		`CHK(upper_region_busy, 1'b1)
		apb(1'b1, `FSG_OFS_CTRL, 32'h10);
		`CHK(upper_region_busy, 1'b0)
		cpu_u.read(1'b1, BT);
		`CHK(fetch_allow, 1'b1)
		cpu_u.store(OP_WRITE, BT);
		done_pulse();
		cpu_u.store(OP_BUF_LOAD, BT);
		`CHK({store_accept, upper_region_busy}, 2'h2)
		end_test("busy_tolerant");
		cpu_u.store(OP_WRITE, HALT);
		`CHK({store_accept, cpu_halt, upper_region_busy}, 3'h6)
		cpu_u.read(1'b1, BEXEC);
		`CHK(fetch_allow, 1'b0)
		apb(1'b0, `FSG_OFS_STATUS, 32'h0);
		`CHK(r[`FSG_STAT_HALT_BIT], 1'b1)
		done_pulse();
		`CHK(cpu_halt, 1'b0)
		end_test("halting");
		apb(1'b1, `FSG_OFS_LOCK, 32'h3E);
		cpu_u.store(OP_WRITE, BT);
		`CHK(store_reject, 1'b1)
		cpu_u.read(1'b0, BT);
		`CHK(load_allow, 1'b1)
		cpu_u.store(OP_WRITE, BOOT);
		`CHK({store_accept, cpu_halt}, 2'h3)
		done_pulse();
		apb(1'b1, `FSG_OFS_LOCK, 32'h3C);
		apb(1'b1, `FSG_OFS_LOCK, 32'h3F);
		apb(1'b0, `FSG_OFS_LOCK, 32'h0);
		`CHK(r, 32'h3C)
		cpu_u.read(1'b0, BT);
		`CHK(load_allow, 1'b0)
		irq_at(AEXEC, 1'b1);
		`CHK(irq_disable, 1'b1)
		irq_at(AEXEC, 1'b0);
		`CHK(irq_disable, 1'b0)
		lock_pulse(1'b0, 6'h00);
		lock_pulse(1'b1, 6'h37);
		apb(1'b0, `FSG_OFS_LOCK, 32'h0);
		`CHK(r, 32'h37)
		cpu_u.read(1'b0, BOOT);
		`CHK(load_allow, 1'b0)
		irq_at(BEXEC, 1'b0);
		`CHK(irq_disable, 1'b1)
		cpu_u.store(OP_ERASE, BOOT);
		`CHK(store_accept, 1'b1)
		done_pulse();
		apb(1'b1, `FSG_OFS_LOCK, 32'h33);
		cpu_u.store(OP_ERASE, BOOT);
		`CHK(store_reject, 1'b1)
		apb(1'b0, `FSG_OFS_STATUS, 32'h0);
		`CHK(r[2:0], 3'h4)
		apb(1'b1, `FSG_OFS_STATUS, 32'h4);
		apb(1'b0, `FSG_OFS_STATUS, 32'h0);
		`CHK(r[2:0], 3'h0)
		end_test("locks");
		lock_pulse(1'b0, 6'h00);
		apb(1'b1, `FSG_OFS_LOCK, 32'h0F);
		cpu_u.store(OP_ERASE, BT);
		`CHK(store_accept, 1'b1)
		apb(1'b0, `FSG_OFS_STATUS, 32'h0);
		`CHK(r[2:0], 3'h1)
		cpu_u.read(1'b0, HALT);
		`CHK(load_allow, 1'b1)
		done_pulse();
		end_test("general_lock");
		finish_test();
	end
endmodule // tb
